//--- hdl/cwp_dcache.sv
// Direct-mapped data cache array with an access port and a snoop port
module cwp_dcache import cwp_pkg::*; #(
   parameter int LINES = CWP_LINES
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [31:0] rd_addr,
   output logic rd_hit,
   output cwp_mesi_e rd_st,
   output logic [31:0] rd_data,
   output logic [31:0] rd_vaddr,
   input wire logic [31:0] sp_addr,
   output logic sp_hit,
   output cwp_mesi_e sp_st,
   output logic [31:0] sp_data,
   input wire logic wr_en,
   input wire logic [31:0] wr_addr,
   input wire logic wr_dat_en,
   input wire logic [31:0] wr_data,
   input wire cwp_mesi_e wr_st
);
   localparam int IW = $clog2(LINES);
   localparam int TW = 30 - IW;

   logic [TW-1:0] tag_q [LINES];
   logic [31:0] data_q [LINES];
   cwp_mesi_e st_q [LINES];
   logic [IW-1:0] ri, si, wi;

   assign ri = rd_addr[IW+1:2];
   assign si = sp_addr[IW+1:2];
   assign wi = wr_addr[IW+1:2];

   // ----------------------------------------------------------------
   // Line state, one flop group per entry
   // ----------------------------------------------------------------
   for (genvar i = 0; i < LINES; i++) begin : g_line
      always_ff @(posedge mclk or negedge rstn) begin
         if (!rstn) begin
            st_q[i] <= CWP_I;
         end else if (wr_en && wi == IW'(i)) begin
            st_q[i] <= wr_st;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (wr_en) begin
         tag_q[wi] <= wr_addr[31:IW+2];
      end
      if (wr_en && wr_dat_en) begin
         data_q[wi] <= wr_data;
      end
   end

   // ----------------------------------------------------------------
   // Lookups
   // ----------------------------------------------------------------
   assign rd_st = st_q[ri];
   assign rd_hit = st_q[ri] != CWP_I && tag_q[ri] == rd_addr[31:IW+2];
   assign rd_data = data_q[ri];
   assign rd_vaddr = {tag_q[ri], ri, 2'b00};
   // Own lookup path so snoops look up sp_addr without using the access port
   assign sp_st = st_q[si];
   assign sp_hit = st_q[si] != CWP_I && tag_q[si] == sp_addr[31:IW+2];
   assign sp_data = data_q[si];
endmodule : cwp_dcache

//--- hdl/cwp_ifetch.sv
// Instruction queue refill control
module cwp_ifetch import cwp_pkg::*; #(
   parameter int DEPTH = CWP_IQ_DEPTH,
   localparam int CW = $clog2(DEPTH + 1)
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic en,
   input wire logic ic_hit,
   input wire logic ic_last_pair,
   input wire logic ic_fill_done,
   input wire logic [CW-1:0] deq_cnt,
   output logic fetch_valid,
   output logic [CW-1:0] fetch_cnt,
   output logic imiss_req,
   output logic [CW-1:0] occ
);
   logic [CW-1:0] occ_q, vac, n_d, fc_q;
   logic miss_q, fv_q, try_fetch, got;

   assign vac = CW'(DEPTH) - occ_q;
   assign try_fetch = en && !miss_q && n_d != '0;
   assign got = try_fetch && ic_hit;

   // Four when room allows and the block has them, else one pair if two fit, else none
   always_comb begin
      if (vac >= CW'(CWP_FETCH_MAX) && !ic_last_pair) begin
         n_d = CW'(CWP_FETCH_MAX);
      end else if (vac >= CW'(CWP_FETCH_PAIR)) begin
         n_d = CW'(CWP_FETCH_PAIR);
      end else begin
         n_d = '0;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         occ_q <= '0;
      end else begin
         occ_q <= occ_q + (got ? n_d : '0) - deq_cnt;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         fv_q <= 1'b0;
         fc_q <= '0;
      end else begin
         fv_q <= got;
         fc_q <= got ? n_d : '0;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         miss_q <= 1'b0;
      end else if (try_fetch && !ic_hit) begin
         miss_q <= 1'b1;
      end else if (ic_fill_done) begin
         miss_q <= 1'b0;
      end
   end

   assign fetch_valid = fv_q;
   assign fetch_cnt = fc_q;
   assign imiss_req = miss_q;
   assign occ = occ_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   property p_fetch_max;
      fv_q |-> fc_q <= CW'(CWP_FETCH_MAX) && fc_q != '0;
   endproperty
   a_fetch_max: assert property (p_fetch_max) else $error("fetch count out of range");

   property p_pair_fill;
      (en && !miss_q && vac == CW'(CWP_FETCH_PAIR) && ic_hit) |=> fv_q && fc_q == CW'(2);
   endproperty
   a_pair_fill: assert property (p_pair_fill) else $error("pair vacancy not filled");

   property p_miss_req;
      (try_fetch && !ic_hit) |=> imiss_req && !fv_q;
   endproperty
   a_miss_req: assert property (p_miss_req) else $error("refill miss not requested");
endmodule : cwp_ifetch

//--- hdl/cwp_top.sv
// Cache memory-update policy, bus snooping and instruction refill control
//
// Design decisions made here: the register addresses and the AHB-Lite register port.
module cwp_top import cwp_pkg::*; #(
   parameter int LINES = CWP_LINES,
   parameter int IQ_DEPTH = CWP_IQ_DEPTH,
   localparam int QW = $clog2(IQ_DEPTH + 1)
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic req_valid,
   input wire cwp_req_s req,
   output logic rsp_valid,
   output logic [31:0] rsp_data,
   output logic bus_valid,
   output cwp_bus_s bus,
   input wire logic bus_ack,
   input wire logic [31:0] bus_rdata,
   input wire logic snp_valid,
   input wire cwp_snp_s snp,
   output logic snp_retry,
   input wire logic ic_hit,
   input wire logic ic_last_pair,
   input wire logic ic_fill_done,
   input wire logic [QW-1:0] deq_cnt,
   output logic fetch_valid,
   output logic [QW-1:0] fetch_cnt,
   output logic imiss_req
);
   typedef enum logic [2:0] {
      ST_IDLE, ST_PUSH, ST_EVICT, ST_FILL, ST_MEMWR, ST_MEMRD, ST_CIWB
   } cwp_state_e;

   cwp_state_e state_q;
   cwp_bus_s bus_q;
   cwp_snp_s snp_q;
   logic bus_valid_q, snp_pend_q, snp_retry_q, rsp_valid_q;
   logic [31:0] rsp_data_q, push_cnt_q, hrdata_q, rd_val;
   logic [1:0] ctrl_q, ctrl_fwd;
   logic [7:0] ap_ofs_q;
   logic ap_wr_q, hreadyout_q, hresp_q, ap_ok;
   logic rd_hit, sp_hit, hit_m, take_snp, take_req, push, hit_serve, rsp_d;
   logic [31:0] rd_data, rd_vaddr, sp_data, rsp_dat_d;
   cwp_mesi_e rd_st, sp_st;
   logic wr_en, wr_dat_en;
   logic [31:0] wr_addr, wr_data;
   cwp_mesi_e wr_st;
   logic [QW-1:0] iq_occ;

   cwp_dcache #(.LINES(LINES)) u_dcache (
      .mclk(mclk), .rstn(rstn),
      .rd_addr(req.addr), .rd_hit(rd_hit), .rd_st(rd_st), .rd_data(rd_data),
      .rd_vaddr(rd_vaddr), .sp_addr(snp_q.addr), .sp_hit(sp_hit), .sp_st(sp_st),
      .sp_data(sp_data), .wr_en(wr_en), .wr_addr(wr_addr), .wr_dat_en(wr_dat_en),
      .wr_data(wr_data), .wr_st(wr_st)
   );

   cwp_ifetch #(.DEPTH(IQ_DEPTH)) u_ifetch (
      .mclk(mclk), .rstn(rstn), .en(ctrl_q[CWP_IF_EN_BIT]), .ic_hit(ic_hit),
      .ic_last_pair(ic_last_pair), .ic_fill_done(ic_fill_done), .deq_cnt(deq_cnt),
      .fetch_valid(fetch_valid), .fetch_cnt(fetch_cnt), .imiss_req(imiss_req),
      .occ(iq_occ)
   );

   // ----------------------------------------------------------------
   // Decisions in idle
   // ----------------------------------------------------------------
   assign take_snp = state_q == ST_IDLE && snp_pend_q;
   // Mode and coherence come with the request from translation
   assign take_req = state_q == ST_IDLE && !snp_pend_q && req_valid && !rsp_valid_q;
   assign push = take_snp && sp_hit && sp_st == CWP_M && snp_q.coh;
   assign hit_m = rd_hit && rd_st == CWP_M;
   assign hit_serve = take_req && req.mode != CWP_CI && rd_hit
                      && (!req.wr || req.mode == CWP_WB);

   // ----------------------------------------------------------------
   // Cache write port
   // ----------------------------------------------------------------
   always_comb begin
      wr_en = 1'b0;
      wr_dat_en = 1'b0;
      wr_addr = req.addr;
      wr_data = req.data;
      wr_st = CWP_I;
      if (take_snp && sp_hit && (sp_st != CWP_M || snp_q.coh)) begin
         wr_en = 1'b1;
         wr_addr = snp_q.addr;
      end else if (take_req && req.mode == CWP_WB && req.wr && rd_hit) begin
         wr_en = 1'b1;
         wr_dat_en = 1'b1;
         wr_st = CWP_M;
      end else if (take_req && req.mode == CWP_WT && req.wr && rd_hit) begin
         wr_en = 1'b1;
         wr_dat_en = 1'b1;
         wr_st = rd_st;
      end else if (take_req && req.mode == CWP_CI && rd_hit && !hit_m) begin
         wr_en = 1'b1;
      end else if (state_q == ST_FILL && bus_ack) begin
         wr_en = 1'b1;
         wr_dat_en = 1'b1;
         wr_data = req.wr ? req.data : bus_rdata;
         wr_st = req.wr ? CWP_M : CWP_E;
      end else if (state_q == ST_CIWB && bus_ack) begin
         wr_en = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Memory transaction sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_q <= ST_IDLE;
         bus_valid_q <= 1'b0;
         bus_q <= '0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (push) begin
                  state_q <= ST_PUSH;
                  bus_valid_q <= 1'b1;
                  bus_q <= '{1'b1, snp_q.addr, sp_data};
               end else if (take_req && req.mode == CWP_CI) begin
                  bus_valid_q <= 1'b1;
                  if (hit_m) begin
                     state_q <= ST_CIWB;
                     bus_q <= '{1'b1, req.addr, rd_data};
                  end else begin
                     state_q <= req.wr ? ST_MEMWR : ST_MEMRD;
                     bus_q <= '{req.wr, req.addr, req.data};
                  end
               end else if (take_req && req.mode == CWP_WT && req.wr) begin
                  state_q <= ST_MEMWR;
                  bus_valid_q <= 1'b1;
                  bus_q <= '{1'b1, req.addr, req.data};
               end else if (take_req && !rd_hit) begin
                  bus_valid_q <= 1'b1;
                  if (rd_st == CWP_M) begin
                     state_q <= ST_EVICT;
                     bus_q <= '{1'b1, rd_vaddr, rd_data};
                  end else begin
                     state_q <= ST_FILL;
                     bus_q <= '{1'b0, req.addr, 32'h0};
                  end
               end
            end
            ST_EVICT: begin
               if (bus_ack) begin
                  state_q <= ST_FILL;
                  bus_q <= '{1'b0, req.addr, 32'h0};
               end
            end
            ST_CIWB: begin
               if (bus_ack) begin
                  state_q <= req.wr ? ST_MEMWR : ST_MEMRD;
                  bus_q <= '{req.wr, req.addr, req.data};
               end
            end
            default: begin
               if (bus_ack) begin
                  state_q <= ST_IDLE;
                  bus_valid_q <= 1'b0;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Response to the load/store unit
   // ----------------------------------------------------------------
   always_comb begin
      rsp_d = hit_serve || (bus_ack && (state_q == ST_FILL || state_q == ST_MEMWR
                                         || state_q == ST_MEMRD));
      if (hit_serve) begin
         rsp_dat_d = rd_data;
      end else if (state_q == ST_FILL && req.wr) begin
         rsp_dat_d = req.data;
      end else begin
         rsp_dat_d = bus_rdata;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rsp_valid_q <= 1'b0;
         rsp_data_q <= 32'h0;
      end else begin
         rsp_valid_q <= rsp_d;
         if (rsp_d) begin
            rsp_data_q <= rsp_dat_d;
         end
      end
   end

   // ----------------------------------------------------------------
   // Snoop capture; a new snoop wins over the consume
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         snp_pend_q <= 1'b0;
         snp_q <= '0;
      end else if (snp_valid && ctrl_q[CWP_SNP_EN_BIT]) begin
         snp_pend_q <= 1'b1;
         snp_q <= snp;
      end else if (take_snp) begin
         snp_pend_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         snp_retry_q <= 1'b0;
         push_cnt_q <= 32'h0;
      end else begin
         snp_retry_q <= push;
         if (push) begin
            push_cnt_q <= push_cnt_q + 32'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // AHB-Lite register slave, zero wait states
   // ----------------------------------------------------------------
   assign ap_ok = hsel && htrans[1] && hready;
   assign ctrl_fwd = (ap_wr_q && ap_ofs_q == CWP_CTRL_OFS) ? hwdata[1:0] : ctrl_q;

   always_comb begin
      case (haddr[7:0])
         CWP_CTRL_OFS: rd_val = {30'h0, ctrl_fwd};
         CWP_STAT_OFS: rd_val = {{(30 - QW){1'b0}}, iq_occ, snp_pend_q, state_q != ST_IDLE};
         CWP_PUSH_OFS: rd_val = push_cnt_q;
         default: rd_val = 32'h0;
      endcase
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ap_wr_q <= 1'b0;
         ap_ofs_q <= 8'h00;
         hrdata_q <= 32'h0;
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
      end else begin
         ap_wr_q <= ap_ok && hwrite;
         ap_ofs_q <= haddr[7:0];
         hrdata_q <= (ap_ok && !hwrite) ? rd_val : 32'h0;
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ctrl_q <= CWP_CTRL_RST;
      end else if (ap_wr_q && ap_ofs_q == CWP_CTRL_OFS) begin
         ctrl_q <= hwdata[1:0];
      end
   end

   assign hrdata = hrdata_q;
   assign hreadyout = hreadyout_q;
   assign hresp = hresp_q;
   assign rsp_valid = rsp_valid_q;
   assign rsp_data = rsp_data_q;
   assign bus_valid = bus_valid_q;
   assign bus = bus_q;
   assign snp_retry = snp_retry_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   property p_wb_store;
      (take_req && req.mode == CWP_WB && req.wr && rd_hit) |=> rsp_valid_q && !bus_valid_q;
   endproperty
   a_wb_store: assert property (p_wb_store) else $error("write-back hit used the bus");

   property p_push;
      push |=> snp_retry_q && bus_valid_q && bus_q.wr && bus_q.addr == $past(snp_q.addr);
   endproperty
   a_push: assert property (p_push) else $error("modified snoop hit not pushed");

   property p_snp_inval;
      (take_snp && sp_hit && sp_st != CWP_M) |=> !snp_retry_q && !bus_valid_q;
   endproperty
   a_snp_inval: assert property (p_snp_inval) else $error("clean snoop hit wrote memory");

   property p_wt_store;
      (take_req && req.mode == CWP_WT && req.wr) |=> bus_valid_q && bus_q.wr
         && bus_q.data == $past(req.data);
   endproperty
   a_wt_store: assert property (p_wt_store) else $error("write-through store missed memory");

   property p_wt_clean;
      (take_req && req.mode == CWP_WT && req.wr && rd_hit && !hit_m) |-> wr_st != CWP_M;
   endproperty
   a_wt_clean: assert property (p_wt_clean) else $error("write-through block made dirty");

   property p_fill_alone;
      (state_q == ST_FILL && bus_valid_q) |-> !bus_q.wr;
   endproperty
   a_fill_alone: assert property (p_fill_alone) else $error("load fill overlaps a store");

   property p_ci_noalloc;
      state_q == ST_FILL |-> req.mode != CWP_CI;
   endproperty
   a_ci_noalloc: assert property (p_ci_noalloc) else $error("inhibited access allocated");

   property p_ci_flush;
      (take_req && req.mode == CWP_CI && hit_m) |=> state_q == ST_CIWB && bus_q.wr;
   endproperty
   a_ci_flush: assert property (p_ci_flush) else $error("dirty inhibited hit not flushed");

   property p_load_hit;
      (hit_serve && !req.wr) |=> rsp_valid_q && rsp_data_q == $past(rd_data);
   endproperty
   a_load_hit: assert property (p_load_hit) else $error("load hit not served from cache");

   property p_one_rsp;
      rsp_valid_q |=> !rsp_valid_q;
   endproperty
   a_one_rsp: assert property (p_one_rsp) else $error("two accesses in back-to-back cycles");
endmodule : cwp_top

//--- shared/cwp_pkg.sv
// Shared constants and types of the cache write-policy block
package cwp_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] CWP_CTRL_OFS = 8'h00;
   localparam logic [7:0] CWP_STAT_OFS = 8'h04;
   localparam logic [7:0] CWP_PUSH_OFS = 8'h08;
   localparam logic [1:0] CWP_CTRL_RST = 2'h3;
   localparam int CWP_SNP_EN_BIT = 0;
   localparam int CWP_IF_EN_BIT = 1;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int CWP_LINES = 16;
   localparam int CWP_IQ_DEPTH = 8;
   localparam int CWP_FETCH_MAX = 4;
   localparam int CWP_FETCH_PAIR = 2;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {CWP_WB, CWP_WT, CWP_CI} cwp_mode_e;
   typedef enum logic [1:0] {CWP_I, CWP_S, CWP_E, CWP_M} cwp_mesi_e;

   typedef struct packed {
      logic wr;
      logic [31:0] addr;
      logic [31:0] data;
      cwp_mode_e mode;
      logic coh;
   } cwp_req_s;

   typedef struct packed {
      logic wr;
      logic [31:0] addr;
      logic [31:0] data;
   } cwp_bus_s;

   typedef struct packed {
      logic [31:0] addr;
      logic coh;
   } cwp_snp_s;
endpackage : cwp_pkg

//--- verif/cwp_mem.sv
// System bus memory model answering the block's bus requests
module cwp_mem import cwp_pkg::*; (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic bus_valid,
   input wire cwp_bus_s bus,
   output logic bus_ack,
   output logic [31:0] bus_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   int wr_cnt = 0;
   int rd_cnt = 0;
   logic [31:0] mem [0:255];
   initial for (int i = 0; i < 256; i++) mem[i] = 32'hc0de0000 + i;
   // ----------------------------------------------------------------
   // Answer, alternately prompt and slow; never ack without a request
   // ----------------------------------------------------------------
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cnt <= 0;
         bus_ack <= 1'b0;
         bus_rdata <= 32'h0;
      end else begin
         bus_ack <= 1'b0;
         bus_rdata <= ~bus_rdata;
         if (bus_valid === 1'b1 && !bus_ack) begin
            if (cnt < ((wr_cnt + rd_cnt) % 2) * 3) begin
               cnt <= cnt + 1;
            end else begin
               cnt <= 0;
               bus_ack <= 1'b1;
               if (bus.wr) begin
                  mem[bus.addr[9:2]] <= bus.data;
                  wr_cnt <= wr_cnt + 1;
               end else begin
                  bus_rdata <= mem[bus.addr[9:2]];
                  rd_cnt <= rd_cnt + 1;
               end
            end
         end
      end
   end
endmodule : cwp_mem

//--- verif/testbench.sv
// Self-checking bench of the cache write-policy block
module testbench import cwp_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 0, rstn = 0, hsel = 0, hwrite = 0, req_valid = 0, snp_valid = 0;
   logic ic_hit = 1, ic_last_pair = 0, ic_fill_done = 0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rsp_data, bus_rdata, q;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [3:0] deq_cnt = 4'h0, fetch_cnt;
   logic hreadyout, hresp, rsp_valid, bus_valid, bus_ack, snp_retry, fetch_valid, imiss_req;
   cwp_req_s req = '0;
   cwp_snp_s snp = '0;
   cwp_bus_s bus;
   int error_cnt = 0, comparisons = 0, n;
   always #2 mclk = ~mclk;
   cwp_top dut (.mclk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .req_valid, .req, .rsp_valid,
      .rsp_data, .bus_valid, .bus, .bus_ack, .bus_rdata, .snp_valid, .snp, .snp_retry,
      .ic_hit, .ic_last_pair, .ic_fill_done, .deq_cnt, .fetch_valid, .fetch_cnt, .imiss_req);
   cwp_mem mem (.mclk, .rstn, .bus_valid, .bus, .bus_ack, .bus_rdata);
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      comparisons++;
      if (s !== e) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : wrap_up
   task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge mclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      // Only the watchdog ends a wait for the slave
      do @(posedge mclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      r = hrdata;
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask : ahb
   task acc(input logic w, input logic [31:0] a, d, input cwp_mode_e m, input int ewr, erd,
      input logic [31:0] eq);
      int w0, r0;
      w0 = mem.wr_cnt;
      r0 = mem.rd_cnt;
      @(posedge mclk);
      req_valid <= 1'b1;
      req <= '{w, a, d, m, 1'b1};
      n = 0;
      do @(posedge mclk) n++; while (rsp_valid !== 1'b1 && n < 100);
      req_valid <= 1'b0;
      chk("rsp_valid", 32'h1, {31'h0, rsp_valid});
      if (!w) chk("rsp_data", eq, rsp_data);
      chk("mem writes", ewr, mem.wr_cnt - w0);
      if (erd >= 0) chk("mem reads", erd, mem.rd_cnt - r0);
   endtask : acc
   task snoop(input logic [31:0] a, input logic coh, input int eret, ewr);
      int w0, seen;
      w0 = mem.wr_cnt;
      seen = 0;
      @(posedge mclk);
      snp_valid <= 1'b1;
      snp <= '{a, coh};
      @(posedge mclk);
      snp_valid <= 1'b0;
      repeat (20) begin
         @(posedge mclk);
         if (snp_retry === 1'b1) seen++;
      end
      chk("snp_retry", eret, seen);
      chk("push writes", ewr, mem.wr_cnt - w0);
   endtask : snoop
   task fq(input logic [3:0] dq, input logic lp, hit, input logic [3:0] e);
      @(posedge mclk);
      deq_cnt <= dq;
      ic_last_pair <= lp;
      ic_hit <= hit;
      @(posedge mclk);
      deq_cnt <= 4'h0;
      n = 0;
      while ((hit ? fetch_valid : imiss_req) !== 1'b1 && n < 20) begin
         @(posedge mclk);
         n++;
      end
      chk(hit ? "fetch_cnt" : "imiss_req", {28'h0, e}, hit ? {28'h0, fetch_cnt} : {31'h0, imiss_req});
      if (!hit) begin
         ic_hit <= 1'b1;
         ic_fill_done <= 1'b1;
         @(posedge mclk);
         ic_fill_done <= 1'b0;
      end
      repeat (8) @(posedge mclk);
   endtask : fq
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge mclk);
      error_cnt++;
      wrap_up();
   end
   initial begin
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      ahb(1'b0, CWP_CTRL_OFS, 32'h0, q);
      chk("ctrl reset", 32'h3, q);
      ahb(1'b0, 8'h40, 32'h0, q);
      chk("unmapped", 32'h0, q);
      acc(1'b1, 32'h100, 32'h11, CWP_WB, 0, -1, 32'h0);
      acc(1'b0, 32'h100, 32'h0, CWP_WB, 0, 0, 32'h11);
      ahb(1'b1, CWP_CTRL_OFS, 32'h2, q);
      snoop(32'h100, 1'b1, 0, 0);
      ahb(1'b1, CWP_CTRL_OFS, 32'h3, q);
      snoop(32'h100, 1'b1, 1, 1);
      chk("pushed data", 32'h11, mem.mem[8'h40]);
      // Preempted master retries and now finds memory up to date
      snoop(32'h100, 1'b1, 0, 0);
      ahb(1'b0, CWP_PUSH_OFS, 32'h0, q);
      chk("push count", 32'h1, q);
      acc(1'b0, 32'h204, 32'h0, CWP_WB, 0, 1, 32'hc0de0081);
      snoop(32'h204, 1'b1, 0, 0);
      acc(1'b0, 32'h204, 32'h0, CWP_WB, 0, 1, 32'hc0de0081);
      acc(1'b1, 32'h308, 32'h55, CWP_WT, 1, 0, 32'h0);
      acc(1'b0, 32'h308, 32'h0, CWP_WT, 0, 1, 32'h55);
      acc(1'b1, 32'h308, 32'h66, CWP_WT, 1, 0, 32'h0);
      acc(1'b0, 32'h308, 32'h0, CWP_WT, 0, 0, 32'h66);
      snoop(32'h308, 1'b1, 0, 0);
      acc(1'b1, 32'h40c, 32'h77, CWP_WB, 0, -1, 32'h0);
      acc(1'b0, 32'h40c, 32'h0, CWP_CI, 1, 1, 32'h77);
      acc(1'b0, 32'h40c, 32'h0, CWP_WB, 0, 1, 32'h77);
      acc(1'b1, 32'h40c, 32'h88, CWP_CI, 1, 0, 32'h0);
      acc(1'b0, 32'h40c, 32'h0, CWP_WB, 0, 1, 32'h88);
      acc(1'b1, 32'h40c, 32'h99, CWP_WB, 0, 0, 32'h0);
      acc(1'b0, 32'h04c, 32'h0, CWP_WB, 1, 1, 32'hc0de0013);
      acc(1'b0, 32'h40c, 32'h0, CWP_WB, 0, 1, 32'h99);
      fq(4'h4, 1'b0, 1'b1, 4'h4);
      ahb(1'b0, CWP_STAT_OFS, 32'h0, q);
      chk("stat", 32'h20, q);
      fq(4'h4, 1'b1, 1'b1, 4'h2);
      fq(4'h2, 1'b0, 1'b1, 4'h2);
      fq(4'h2, 1'b0, 1'b0, 4'h1);
      wrap_up();
   end
endmodule : testbench
